// ---- hdl/rml_cfg.svh ----
`ifndef RML_CFG_SVH
`define RML_CFG_SVH

`define RML_ADDR_W     12
`define RML_OFF_CTRL   12'h000
`define RML_OFF_ISTAT  12'h004
`define RML_OFF_IMASK  12'h008
`define RML_OFF_MODE   12'h00C

`define RML_BIT_FLAG   0
`define RML_BIT_EN     1
`define RML_BIT_STAT   2
`define RML_CTRL_W     8

`define RML_IEV_DROP   0
`define RML_IEV_MODE   1
`define RML_IEV_W      2
`define RML_IMASK_RST  2'h0

`define RML_SYNC_W     7

`endif

// ---- hdl/rml_mode_ctrl.sv ----
`default_nettype none

module rml_mode_ctrl
  import rml_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          regulator_enable_input,
  input  wire logic          mcu_stop,
  output rml_pkg::rml_mode_e mode
);

  rml_mode_e next_mode;

  always_comb begin
    case (mode)
      MODE_SHUT, MODE_FULL, MODE_RED: begin
        if (!regulator_enable_input) begin
          next_mode = MODE_SHUT;
        end else if (mcu_stop) begin
          next_mode = MODE_RED;
        end else begin
          next_mode = MODE_FULL;
        end
      end
      default: begin
        next_mode = MODE_SHUT;
      end
    endcase
  end

  // Shutdown is the safe start: detector and drop reset stay off
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= MODE_SHUT;
    end else begin
      mode <= next_mode;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  shutdown_entry_a: assert property (!regulator_enable_input |=> mode == MODE_SHUT)
    else $error("enable low did not select shutdown");
  stop_select_a: assert property (
    regulator_enable_input && mcu_stop |=> mode == MODE_RED)
    else $error("stop did not select reduced power");
  run_select_a: assert property (
    regulator_enable_input && !mcu_stop |=> mode == MODE_FULL)
    else $error("run did not select full performance");

endmodule : rml_mode_ctrl

`default_nettype wire

// ---- hdl/rml_pkg.sv ----
`include "rml_cfg.svh"
`default_nettype none

package rml_pkg;

  typedef logic [`RML_ADDR_W-1:0] rml_addr_t;

  typedef enum logic [2:0] {
    MODE_SHUT = 3'b001,
    MODE_FULL = 3'b010,
    MODE_RED  = 3'b100
  } rml_mode_e;

endpackage : rml_pkg

`default_nettype wire

// ---- hdl/rml_sync.sv ----
`default_nettype none

module rml_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end

endmodule : rml_sync

`default_nettype wire

// ---- hdl/rml_top.sv ----
// What this block does
// - The low-voltage status bit at bit 2 is read-only, follows the comparator, ignores writes.
// - The status bit sets below the assert level, clears above the deassert level, and reads 1 only in full mode.
// - The interrupt flag at bit 0 is set whenever the status bit changes, either way.
// - The interrupt flag clears only by writing 1 to it; writing 0 leaves it alone.
// - The interrupt request is raised while the flag is set and the enable at bit 1 is 1.
// - Entering reduced power mode does not clear the interrupt flag.
// - The detector updates only in full performance mode and is idle otherwise.
// - The power-up reset is high while the core supply is below threshold, in every mode.
// - The drop reset follows assert and deassert levels and works only in full mode.
// - Shutdown mode is held while the regulator enable input is low.
// - Reduced power mode is used while the MCU is stopped, full performance otherwise.
//
// The APB register port was chosen for this implementation.
`include "rml_cfg.svh"
`default_nettype none

module rml_top
  import rml_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire rml_pkg::rml_addr_t paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              vdda_below_assert,
  input  wire logic              vdda_above_deassert,
  input  wire logic              vdd_below_por,
  input  wire logic              vdd_below_drop_assert,
  input  wire logic              vdd_above_drop_deassert,
  input  wire logic              regulator_enable_input,
  input  wire logic              mcu_stop,
  output logic                   low_voltage_interrupt,
  output logic                   irq,
  output logic                   power_up_reset,
  output logic                   supply_drop_reset,
  output logic                   full_performance_mode,
  output logic                   reduced_power_mode,
  output logic                   shutdown_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers and mode control

  logic [`RML_SYNC_W-1:0] sync_out;
  logic                   lv_below_s;
  logic                   lv_above_s;
  logic                   por_s;
  logic                   drop_below_s;
  logic                   drop_above_s;
  logic                   en_s;
  logic                   stop_s;
  rml_mode_e              mode;
  logic                   mode_full;

  rml_sync #(
    .W (`RML_SYNC_W)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     ({mcu_stop, regulator_enable_input, vdd_above_drop_deassert,
                vdd_below_drop_assert, vdd_below_por, vdda_above_deassert,
                vdda_below_assert}),
    .dout    (sync_out)
  );

  assign lv_below_s   = sync_out[0];
  assign lv_above_s   = sync_out[1];
  assign por_s        = sync_out[2];
  assign drop_below_s = sync_out[3];
  assign drop_above_s = sync_out[4];
  assign en_s         = sync_out[5];
  assign stop_s       = sync_out[6];

  rml_mode_ctrl u_mode (
    .clk                    (clk),
    .reset_n                (reset_n),
    .regulator_enable_input (en_s),
    .mcu_stop               (stop_s),
    .mode                   (mode)
  );

  assign mode_full = (mode == MODE_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  function automatic logic addr_hit(input rml_addr_t a, input rml_addr_t off);
    addr_hit = (a == off);
  endfunction : addr_hit

  logic acc;
  logic commit;
  logic wr_ctl;
  logic wr_istat;
  logic wr_imask;
  logic mapped;

  // Answer one cycle into the access phase; writes land on the pready edge
  assign acc      = psel & penable & ~pready;
  assign commit   = psel & penable & pready & pwrite;
  assign wr_ctl   = commit & addr_hit(paddr, `RML_OFF_CTRL);
  assign wr_istat = commit & addr_hit(paddr, `RML_OFF_ISTAT);
  assign wr_imask = commit & addr_hit(paddr, `RML_OFF_IMASK);
  assign mapped   = addr_hit(paddr, `RML_OFF_CTRL) | addr_hit(paddr, `RML_OFF_ISTAT) |
                    addr_hit(paddr, `RML_OFF_IMASK) | addr_hit(paddr, `RML_OFF_MODE);

  ////////////////////////////////////////////////////////////////////////////
  // Detector, resets, flags and outputs

  logic                  lv_status;
  logic                  lv_enable;
  logic                  lv_flag;
  logic                  drop;
  logic [`RML_IEV_W-1:0] istat;
  logic [`RML_IEV_W-1:0] imask;
  rml_mode_e             mode_prev;

  logic                  next_lv_status;
  logic                  next_lv_enable;
  logic                  next_lv_flag;
  logic                  next_drop;
  logic [`RML_IEV_W-1:0] next_istat;
  logic [`RML_IEV_W-1:0] next_imask;
  logic [`RML_IEV_W-1:0] events;
  logic [31:0]           next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;
  logic                  next_lvi;
  logic                  next_irq;
  logic [`RML_CTRL_W-1:0] ctrl_rd;

  always_comb begin
    // Hysteresis between the two comparator levels; cleared outside full mode
    next_lv_status = 1'b0;
    if (mode_full) begin
      if (lv_below_s) begin
        next_lv_status = 1'b1;
      end else if (lv_above_s) begin
        next_lv_status = 1'b0;
      end else begin
        next_lv_status = lv_status;
      end
    end

    next_drop = 1'b0;
    if (mode_full) begin
      if (drop_below_s) begin
        next_drop = 1'b1;
      end else if (drop_above_s) begin
        next_drop = 1'b0;
      end else begin
        next_drop = drop;
      end
    end

    next_lv_enable = wr_ctl ? pwdata[`RML_BIT_EN] : lv_enable;
    // Set beats clear; mode changes never clear the flag
    next_lv_flag = (lv_flag & ~(wr_ctl & pwdata[`RML_BIT_FLAG]))
                   | (next_lv_status != lv_status);

    events[`RML_IEV_DROP] = next_drop & ~drop;
    events[`RML_IEV_MODE] = (mode != mode_prev);
    next_istat = (istat & ~(wr_istat ? pwdata[`RML_IEV_W-1:0] : '0)) | events;
    next_imask = wr_imask ? pwdata[`RML_IEV_W-1:0] : imask;

    next_lvi = lv_flag & lv_enable;
    next_irq = next_lvi | (|(istat & imask));

    ctrl_rd                  = '0;
    ctrl_rd[`RML_BIT_STAT]   = lv_status;
    ctrl_rd[`RML_BIT_EN]     = lv_enable;
    ctrl_rd[`RML_BIT_FLAG]   = lv_flag;

    next_pready  = acc;
    next_pslverr = acc & ~mapped;
    next_prdata  = '0;
    if (acc && !pwrite) begin
      if (addr_hit(paddr, `RML_OFF_CTRL)) begin
        next_prdata = {24'h000000, ctrl_rd};
      end else if (addr_hit(paddr, `RML_OFF_ISTAT)) begin
        next_prdata = {30'h0, istat};
      end else if (addr_hit(paddr, `RML_OFF_IMASK)) begin
        next_prdata = {30'h0, imask};
      end else if (addr_hit(paddr, `RML_OFF_MODE)) begin
        next_prdata = {29'h0, mode};
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lv_status             <= 1'b0;
      lv_enable             <= 1'b0;
      lv_flag               <= 1'b0;
      drop                  <= 1'b0;
      istat                 <= '0;
      imask                 <= `RML_IMASK_RST;
      mode_prev             <= MODE_SHUT;
      prdata                <= '0;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      low_voltage_interrupt <= 1'b0;
      irq                   <= 1'b0;
      power_up_reset        <= 1'b1;
      supply_drop_reset     <= 1'b0;
      full_performance_mode <= 1'b0;
      reduced_power_mode    <= 1'b0;
      shutdown_mode         <= 1'b1;
    end else begin
      lv_status             <= next_lv_status;
      lv_enable             <= next_lv_enable;
      lv_flag               <= next_lv_flag;
      drop                  <= next_drop;
      istat                 <= next_istat;
      imask                 <= next_imask;
      mode_prev             <= mode;
      prdata                <= next_prdata;
      pready                <= next_pready;
      pslverr               <= next_pslverr;
      low_voltage_interrupt <= next_lvi;
      irq                   <= next_irq;
      power_up_reset        <= por_s;
      supply_drop_reset     <= drop;
      full_performance_mode <= mode_full;
      reduced_power_mode    <= (mode == MODE_RED);
      shutdown_mode         <= (mode == MODE_SHUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  status_ro_a: assert property (
    wr_ctl && pwdata[`RML_BIT_STAT] && !lv_status && !lv_below_s |=> !lv_status)
    else $error("write moved the status bit");
  status_full_a: assert property (lv_status |-> $past(mode_full))
    else $error("status set outside full mode");
  flag_on_change_a: assert property ($changed(lv_status) |-> lv_flag)
    else $error("status change did not set flag");
  flag_hold_a: assert property (
    lv_flag && !(wr_ctl && pwdata[`RML_BIT_FLAG]) |=> lv_flag)
    else $error("flag lost without a clearing write");
  lvi_request_a: assert property (
    lv_flag && lv_enable |=> low_voltage_interrupt && irq)
    else $error("enabled flag gave no request");
  lvi_quiet_a: assert property (!lv_enable |=> !low_voltage_interrupt)
    else $error("request with enable clear");
  flag_red_a: assert property (
    lv_flag && mode == MODE_RED && !commit |=> lv_flag)
    else $error("reduced power cleared flag");
  detector_idle_a: assert property (!mode_full |=> !lv_status)
    else $error("detector active outside full mode");
  por_follow_a: assert property (reset_n |=> power_up_reset == $past(por_s))
    else $error("power-up reset does not follow supply");
  drop_full_a: assert property (supply_drop_reset |-> $past(mode_full, 2))
    else $error("drop reset outside full mode");
  ctrl_upper_a: assert property (
    pready && !pslverr && addr_hit($past(paddr), `RML_OFF_CTRL)
    |-> prdata[31:`RML_BIT_STAT+1] == '0)
    else $error("upper control bits not zero");

  // Edge-by-edge effects; guards against a set losing to a same-cycle clear
  status_follow_a: assert property (mode_full && lv_below_s |=> lv_status)
    else $error("status missed a low input");
  status_clear_a: assert property (
    mode_full && !lv_below_s && lv_above_s |=> !lv_status)
    else $error("status stayed set above level");
  flag_set_wins_a: assert property (next_lv_status != lv_status |=> lv_flag)
    else $error("change lost to a clearing write");
  flag_clear_a: assert property (
    wr_ctl && pwdata[`RML_BIT_FLAG] && next_lv_status == lv_status |=> !lv_flag)
    else $error("flag survived a clearing write");
  drop_assert_a: assert property (mode_full && drop_below_s |=> ##1 supply_drop_reset)
    else $error("drop reset did not assert");
  drop_release_a: assert property (
    mode_full && !drop_below_s && drop_above_s |=> ##1 !supply_drop_reset)
    else $error("drop reset did not release");
  lvi_irq_a: assert property (low_voltage_interrupt |-> irq)
    else $error("request missing from irq line");
  mode_onehot_a: assert property (
    $onehot({full_performance_mode, reduced_power_mode, shutdown_mode}))
    else $error("mode outputs not one-hot");
  shut_output_a: assert property (mode == MODE_SHUT |=> shutdown_mode)
    else $error("shutdown not shown on output");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready stood two cycles");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

endmodule : rml_top

`default_nettype wire

// ---- verification/regulator_mode_lvd_control_tb.sv ----
`include "rml_cfg.svh"
`default_nettype none

module regulator_mode_lvd_control_tb;
  import rml_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  rml_addr_t   paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, er, stop_req = 0, strap = 1;
  logic        vdda_below_assert = 0, vdda_above_deassert = 1, vdd_below_por = 0;
  logic        vdd_below_drop_assert = 0, vdd_above_drop_deassert = 1;
  logic        regulator_enable_input, mcu_stop, low_voltage_interrupt, irq;
  logic        power_up_reset, supply_drop_reset;
  logic        full_performance_mode, reduced_power_mode, shutdown_mode;
  int          bad_count = 0, check_count = 0;

  always #12.5 clk = ~clk;

  rml_top dut (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .vdda_below_assert, .vdda_above_deassert, .vdd_below_por,
    .vdd_below_drop_assert, .vdd_above_drop_deassert, .regulator_enable_input,
    .mcu_stop, .low_voltage_interrupt, .irq, .power_up_reset, .supply_drop_reset,
    .full_performance_mode, .reduced_power_mode, .shutdown_mode);

  rml_mcu_model mcu (.clk, .reset_n, .stop_req, .regen_strap(strap), .power_up_reset,
    .mcu_stop, .regulator_enable_input);

  ////////////////////////////////////////
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t word %h want %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t pin %b want %b", $time, got, exp);
    end
  endtask : chk1

  // No cycle limit here; only the watchdog ends a stuck bus
  task automatic apb(input logic wr, input rml_addr_t a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    // One wait state: answer seen at the second edge of the access phase
    chk1(n == 2, 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input rml_addr_t a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk32(rd, exp);
    chk1(er, 1'b0);
  endtask : rd_chk

  // Covers two sync flops, mode register and output stage
  task automatic settle;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic vdda(input logic lo);
    @(posedge clk);
    vdda_below_assert   <= lo;
    vdda_above_deassert <= !lo;
    settle;
  endtask : vdda

  task automatic drop(input logic lo);
    @(posedge clk);
    vdd_below_drop_assert   <= lo;
    vdd_above_drop_deassert <= !lo;
    settle;
  endtask : drop

  task automatic stop_set(input logic s);
    @(posedge clk);
    stop_req <= s;
    settle;
  endtask : stop_set

  ////////////////////////////////////////
  task automatic t_reset;
    rd_chk(`RML_OFF_CTRL, 32'h00000000);
    rd_chk(`RML_OFF_IMASK, 32'h00000000);
    rd_chk(`RML_OFF_MODE, {29'h0, MODE_FULL});
    chk1(full_performance_mode, 1'b1);
    chk1(power_up_reset, 1'b0);
    chk1(irq, 1'b0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_lvd;
    vdda(1'b1);
    rd_chk(`RML_OFF_CTRL, 32'h00000005);
    apb(1'b1, `RML_OFF_CTRL, 32'hFFFFFFFF);
    rd_chk(`RML_OFF_CTRL, 32'h00000006);
    vdda(1'b0);
    rd_chk(`RML_OFF_CTRL, 32'h00000003);
    chk1(low_voltage_interrupt, 1'b1);
    chk1(irq, 1'b1);
    $display("detector test done");
  endtask : t_lvd

  task automatic t_flag;
    apb(1'b1, `RML_OFF_CTRL, 32'h00000002);
    rd_chk(`RML_OFF_CTRL, 32'h00000003);
    apb(1'b1, `RML_OFF_CTRL, 32'h00000000);
    settle;
    chk1(low_voltage_interrupt, 1'b0);
    rd_chk(`RML_OFF_CTRL, 32'h00000001);
    $display("flag test done");
  endtask : t_flag

  task automatic t_reduced;
    stop_set(1'b1);
    chk1(reduced_power_mode, 1'b1);
    rd_chk(`RML_OFF_CTRL, 32'h00000001);
    vdda(1'b1);
    drop(1'b1);
    rd_chk(`RML_OFF_CTRL, 32'h00000001);
    chk1(supply_drop_reset, 1'b0);
    @(posedge clk);
    vdd_below_por <= 1'b1;
    settle;
    chk1(power_up_reset, 1'b1);
    @(posedge clk);
    vdd_below_por <= 1'b0;
    stop_set(1'b0);
    chk1(supply_drop_reset, 1'b1);
    rd_chk(`RML_OFF_CTRL, 32'h00000005);
    drop(1'b0);
    chk1(supply_drop_reset, 1'b0);
    vdda(1'b0);
    apb(1'b1, `RML_OFF_CTRL, 32'h00000001);
    rd_chk(`RML_OFF_CTRL, 32'h00000000);
    $display("reduced mode test done");
  endtask : t_reduced

  task automatic t_irqs;
    apb(1'b1, `RML_OFF_ISTAT, 32'h00000003);
    rd_chk(`RML_OFF_ISTAT, 32'h00000000);
    apb(1'b1, `RML_OFF_IMASK, 32'h00000002);
    rd_chk(`RML_OFF_IMASK, 32'h00000002);
    stop_set(1'b1);
    chk1(irq, 1'b1);
    rd_chk(`RML_OFF_ISTAT, 32'h00000002);
    apb(1'b1, `RML_OFF_IMASK, 32'h00000000);
    settle;
    chk1(irq, 1'b0);
    apb(1'b1, `RML_OFF_ISTAT, 32'h00000002);
    rd_chk(`RML_OFF_ISTAT, 32'h00000000);
    stop_set(1'b0);
    $display("interrupt test done");
  endtask : t_irqs

  task automatic t_shutdown;
    @(posedge clk);
    vdd_below_por <= 1'b1;
    strap         <= 1'b0;
    settle;
    chk1(power_up_reset, 1'b1);
    chk1(shutdown_mode, 1'b1);
    rd_chk(`RML_OFF_MODE, {29'h0, MODE_SHUT});
    @(posedge clk);
    strap <= 1'b1;
    settle;
    @(posedge clk);
    vdd_below_por <= 1'b0;
    settle;
    chk1(full_performance_mode, 1'b1);
    $display("shutdown test done");
  endtask : t_shutdown

  task automatic t_unmapped;
    apb(1'b1, 12'h010, 32'h00000002);
    chk1(er, 1'b1);
    apb(1'b0, 12'h010, 32'h00000000);
    chk1(er, 1'b1);
    chk32(rd, 32'h00000000);
    rd_chk(`RML_OFF_CTRL, 32'h00000000);
    $display("unmapped test done");
  endtask : t_unmapped

  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    settle;
    t_reset;
    t_lvd;
    t_flag;
    t_reduced;
    t_irqs;
    t_shutdown;
    t_unmapped;
    report_and_stop;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
endmodule : regulator_mode_lvd_control_tb

`default_nettype wire

// ---- verification/rml_mcu_model.sv ----
`default_nettype none

module rml_mcu_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic stop_req,
  input  wire logic regen_strap,
  input  wire logic power_up_reset,
  output logic      mcu_stop,
  output logic      regulator_enable_input
);
  timeunit 1ns;
  timeprecision 100ps;

  // Strap is taken during reset and while the core is held unpowered
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mcu_stop               <= 1'b0;
      regulator_enable_input <= regen_strap;
    end else begin
      mcu_stop <= stop_req;
      if (power_up_reset) begin
        regulator_enable_input <= regen_strap;
      end
    end
  end
endmodule : rml_mcu_model

`default_nettype wire
